// File: lts_pkg.sv
package lts_pkg;
    // ------------------------------
    // training-state codes
    // ------------------------------
    localparam logic [5:0] ST_DET_QUIET    = 6'h00;
    localparam logic [5:0] ST_DET_ACTIVE   = 6'h02;
    localparam logic [5:0] ST_POLL_ACTIVE  = 6'h04;
    localparam logic [5:0] ST_POLL_CFG     = 6'h05;
    localparam logic [5:0] ST_COMP_FIRST   = 6'h06;
    localparam logic [5:0] ST_COMP_LAST    = 6'h0A;
    localparam logic [5:0] ST_CFG_LW_FIRST = 6'h0B;
    localparam logic [5:0] ST_CFG_LW_LAST  = 6'h0E;
    localparam logic [5:0] ST_CFG_LN_WAIT  = 6'h0F;
    localparam logic [5:0] ST_CFG_LN_ACC   = 6'h10;
    localparam logic [5:0] ST_CFG_CPL_X1   = 6'h11;
    localparam logic [5:0] ST_CFG_CPL_X8   = 6'h14;
    localparam logic [5:0] ST_CFG_IDLE     = 6'h15;
    localparam logic [5:0] ST_ACTIVE       = 6'h16;
    localparam logic [5:0] ST_HOT_RESET    = 6'h21;
    localparam logic [5:0] ST_DIS_FIRST    = 6'h22;
    localparam logic [5:0] ST_DIS_LAST     = 6'h24;
    localparam logic [5:0] ST_DIS_IDLE     = 6'h25;
    localparam logic [5:0] ST_RP_LW_FIRST  = 6'h26;
    localparam logic [5:0] ST_RP_LW_LAST   = 6'h28;
    localparam logic [5:0] ST_RP_WA_FIRST  = 6'h29;
    localparam logic [5:0] ST_RP_WA_LAST   = 6'h2A;
    localparam logic [5:0] ST_RP_LN_WAIT   = 6'h2B;
    localparam logic [5:0] ST_RP_LN_ACC    = 6'h2C;
    localparam logic [5:0] ST_TIMEOUT_DET  = 6'h2D;
    localparam logic [5:0] ST_LB_ENTRY0    = 6'h2E;
    localparam logic [5:0] ST_LB_ENTRY1    = 6'h2F;
    localparam logic [5:0] ST_LB_ACTIVE    = 6'h30;
    localparam logic [5:0] ST_LB_EXIT0     = 6'h31;
    localparam logic [5:0] ST_LB_EXIT1     = 6'h32;
    localparam logic [5:0] ST_LB_MASTER    = 6'h33;

    // ------------------------------
    // receive status encodings
    // ------------------------------
    localparam logic [2:0] RXS_OK        = 3'h0;
    localparam logic [2:0] RXS_SKP_ADD   = 3'h1;
    localparam logic [2:0] RXS_SKP_DEL   = 3'h2;
    localparam logic [2:0] RXS_DETECTED  = 3'h3;
    localparam logic [2:0] RXS_DEC_ERR   = 3'h4;
    localparam logic [2:0] RXS_EB_OVER   = 3'h5;
    localparam logic [2:0] RXS_EB_UNDER  = 3'h6;
    localparam logic [2:0] RXS_DISP_ERR  = 3'h7;

    // ------------------------------
    // register map (32-bit words)
    // ------------------------------
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATE     = 12'h004;
    localparam logic [11:0] REG_DETECT    = 12'h008;
    localparam logic [11:0] REG_RXSTAT    = 12'h00C;
    localparam logic [11:0] REG_IRQ_STAT  = 12'h010;
    localparam logic [11:0] REG_IRQ_EN    = 12'h014;
    localparam logic [11:0] REG_IRQ_CLR   = 12'h018;

    // control bits
    localparam int CTRL_DET_REQ  = 0;
    localparam int CTRL_RX_RST   = 1;
    localparam int CTRL_TX_RST   = 2;
    localparam int CTRL_ROOT     = 3;
    localparam int CTRL_LOOPBACK = 4;
    localparam int CTRL_DISABLE  = 5;
    localparam int CTRL_HOTRST   = 6;

    // interrupt bits
    localparam int IRQ_DET_DONE  = 0;
    localparam int IRQ_RX_DONE   = 1;
    localparam int IRQ_TX_DONE   = 2;
    localparam int IRQ_LINK_UP   = 3;
    localparam int IRQ_TIMEOUT   = 4;
    localparam int IRQ_RX_ERR    = 5;
    localparam int IRQ_BITS      = 6;

    // ------------------------------
    // timing
    // ------------------------------
    localparam int CLK_NS          = 50;
    localparam int DET_TIME_NS     = 1000;
    localparam int DET_CYCLES      = (DET_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_TIME_NS     = 800;
    localparam int RST_CYCLES      = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_CYCLES     = 4;
    localparam int TRAIN_TO_CYCLES = 2400;
endpackage

// File: lts_reset_seq.sv
`timescale 1ns/1ps
// one channel reset sequencer: pulse on req, then done after a settle delay
module lts_reset_seq
    import lts_pkg::*;
#(
    parameter int SETTLE = RST_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      rst_pulse,
    output logic      done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
        logic        pulse;
        logic        done;
    } lts_rs_t;

    lts_rs_t s_reg, s_next;

    initial begin
        if (SETTLE < 1 || SETTLE > 65535) $error("lts_reset_seq: bad SETTLE");
    end

    // ------------------------------
    // sequence
    // ------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pulse = 1'b0;
        if (start) begin
            s_next.pulse = 1'b1;            // [R14]
            s_next.busy  = 1'b1;
            s_next.done  = 1'b0;
            s_next.cnt   = 16'(SETTLE);
        end else if (s_reg.busy) begin
            if (s_reg.cnt == 16'h0001) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;         // [R15] [R16]
            end
            s_next.cnt = s_reg.cnt - 16'h0001;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rst_pulse = s_reg.pulse;
    assign done      = s_reg.done;
endmodule

// File: lts_detect_lane.sv
`timescale 1ns/1ps
// per-lane receiver detection responder
module lts_detect_lane
    import lts_pkg::*;
#(
    parameter int DET_CNT = DET_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       tx_detect_rx,
    input  wire logic       partner_present,
    input  wire logic [2:0] rx_event,
    output logic            phy_status,
    output logic [2:0]      rx_status,
    output logic            present
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       busy;
        logic       req_d;
        logic       phy;
        logic [2:0] stat;
        logic       present;
        logic       p_s1;
        logic       p_s2;
    } lts_dl_t;

    lts_dl_t s_reg, s_next;

    initial begin
        if (DET_CNT < 1 || DET_CNT > 255) $error("lts_detect_lane: bad DET_CNT");
    end

    // ------------------------------
    // detection handshake and receive status
    // ------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.p_s1  = partner_present;
        s_next.p_s2  = s_reg.p_s1;
        s_next.req_d = tx_detect_rx;
        s_next.phy   = 1'b0;
        if (tx_detect_rx && !s_reg.req_d && !s_reg.busy) begin
            s_next.busy = 1'b1;             // [R07]
            s_next.cnt  = 8'(DET_CNT);
        end else if (s_reg.busy) begin
            if (s_reg.cnt == 8'h01) begin
                s_next.busy    = 1'b0;
                s_next.phy     = 1'b1;      // [R08] [R10]
                // only the two legal detection results
                s_next.stat    = s_reg.p_s2 ? RXS_DETECTED : RXS_OK; // [R11]
                s_next.present = s_reg.p_s2; // [R19]
            end
            s_next.cnt = s_reg.cnt - 8'h01;
        end else if (s_reg.present) begin
            // normal receive: pass through data/error codes, no detect code
            s_next.stat = (rx_event == RXS_DETECTED) ? RXS_OK : rx_event; // [R12] [R13]
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign phy_status = s_reg.phy;
    assign rx_status  = s_reg.stat;
    assign present    = s_reg.present;
endmodule

// File: lts_monitor.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Functional notes
// [R01] polling codes 4, 5, compliance 6..A
// [R02] configuration codes B..15 by substate
// [R03] hot reset 21, disabled 22..25
// [R04] root port codes 26..2C
// [R05] timeout toward detect reports 2D
// [R06] loopback codes 2E..33
// [R07] controller raises detect request to start
// [R08] completion strobe with valid detect result
// [R09] completion strobe also for power/rate changes
// [R10] completion strobe driven high on detect done
// [R11] detect result only 000 or 011
// [R12] normal status 000, 001, 010
// [R13] error status 100, 101, 110, 111
// [R14] channel reset is pulsed high then low
// [R15] receive reset done after receive reset
// [R16] transmit reset done after transmit reset
// [R17] six-bit training code always observable
// [R18] trained link reads code 16
// [R19] hold lane result, no-receiver lanes unused
module lts_monitor
    import lts_pkg::*;
#(
    parameter int LANES    = 4,
    parameter int TRAIN_TO = TRAIN_TO_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic [LANES-1:0]   partner_present,
    input  wire logic [3*LANES-1:0] rx_event,
    input  wire logic               pm_rate_req,
    output logic [5:0]              training_state_code,
    output logic [LANES-1:0]        phy_status,
    output logic [3*LANES-1:0]      rx_status,
    output logic                    rx_channel_reset_req,
    output logic                    tx_channel_reset_req,
    output logic                    rx_reset_done,
    output logic                    tx_reset_done,
    output logic                    irq
);
    import lts_pkg::*;

    typedef enum logic [3:0] {
        TS_DET_QUIET = 4'b0000,
        TS_DET_ACT   = 4'b0001,
        TS_POLL      = 4'b0010,
        TS_COMP      = 4'b0011,
        TS_CFG       = 4'b0100,
        TS_L0        = 4'b0101,
        TS_HOTRST    = 4'b0110,
        TS_DIS       = 4'b0111,
        TS_LOOP      = 4'b1000,
        TS_TIMEOUT   = 4'b1001
    } lts_phase_t;

    typedef struct packed {
        lts_phase_t          phase;
        logic [5:0]          code;
        logic [3:0]          step;
        logic [15:0]         timer;
        logic [7:0]          ctrl;
        logic [IRQ_BITS-1:0] irq_stat;
        logic [IRQ_BITS-1:0] irq_en;
        logic [31:0]         rdata;
        logic                pm_d;
        logic                pm_phy;
        logic                rxd_d;
        logic                txd_d;
    } lts_mon_t;

    lts_mon_t s_reg, s_next;

    logic [LANES-1:0] det_phy;
    logic [LANES-1:0] present;
    logic             rx_pulse;
    logic             tx_pulse;
    logic             rx_done;
    logic             tx_done;
    logic             det_req;
    logic             wr_en;
    logic             rd_en;

    initial begin
        if (LANES < 1 || LANES > 8) $error("lts_monitor: LANES must be 1..8");
        if (TRAIN_TO < 16 || TRAIN_TO > 65535) $error("lts_monitor: bad TRAIN_TO");
    end

    // count present lanes to pick the completion width code
    function automatic logic [5:0] width_code(input logic [LANES-1:0] p);
        int n;
        n = 0;
        for (int i = 0; i < LANES; i++) begin
            if (p[i]) n++;
        end
        if (n >= 8) return ST_CFG_CPL_X8;
        if (n >= 4) return ST_CFG_CPL_X1 + 6'h02;
        if (n >= 2) return ST_CFG_CPL_X1 + 6'h01;
        return ST_CFG_CPL_X1;
    endfunction

    // ------------------------------
    // lanes and reset sequencers
    // ------------------------------
    assign det_req = s_reg.ctrl[CTRL_DET_REQ];

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        lts_detect_lane u_lane (
            .ref_clk         (ref_clk),
            .reset           (reset),
            .tx_detect_rx    (det_req),
            .partner_present (partner_present[g]),
            .rx_event        (rx_event[3*g +: 3]),
            .phy_status      (det_phy[g]),
            .rx_status       (rx_status[3*g +: 3]),
            .present         (present[g])
        );
    end

    lts_reset_seq u_rx_rst (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .start     (wr_en && paddr == REG_CTRL && pwdata[CTRL_RX_RST]),
        .rst_pulse (rx_pulse),
        .done      (rx_done)
    );

    lts_reset_seq u_tx_rst (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .start     (wr_en && paddr == REG_CTRL && pwdata[CTRL_TX_RST]),
        .rst_pulse (tx_pulse),
        .done      (tx_done)
    );

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // ------------------------------
    // training sequence, registers, interrupts
    // ------------------------------
    always_comb begin
        logic [IRQ_BITS-1:0] ev;
        ev = '0;
        s_next = s_reg;
        s_next.pm_d   = pm_rate_req;
        s_next.pm_phy = pm_rate_req && !s_reg.pm_d;          // [R09]
        s_next.rxd_d  = rx_done;
        s_next.txd_d  = tx_done;
        s_next.ctrl[CTRL_DET_REQ] = 1'b0;
        s_next.timer  = s_reg.timer + 16'h0001;
        s_next.step   = s_reg.step + 4'h1;

        case (s_reg.phase)
            TS_DET_QUIET: begin
                s_next.code = ST_DET_QUIET;
                if (s_reg.step == 4'(STEP_CYCLES)) begin
                    s_next.ctrl[CTRL_DET_REQ] = 1'b1;        // [R07]
                    s_next.phase = TS_DET_ACT;
                    s_next.timer = '0;
                end
            end
            TS_DET_ACT: begin
                s_next.code = ST_DET_ACTIVE;
                if (|det_phy) begin
                    ev[IRQ_DET_DONE] = 1'b1;
                    s_next.step  = '0;
                    s_next.phase = (|present) ? TS_POLL : TS_DET_QUIET; // [R19]
                end
            end
            TS_POLL: begin
                s_next.code = (s_reg.step < 4'(STEP_CYCLES)) ? ST_POLL_ACTIVE
                                                              : ST_POLL_CFG; // [R01]
                if (s_reg.step == 4'(2*STEP_CYCLES)) begin
                    s_next.step  = '0;
                    s_next.phase = s_reg.ctrl[CTRL_LOOPBACK] ? TS_LOOP : TS_CFG;
                end
            end
            TS_COMP: begin
                s_next.code = ST_COMP_FIRST + 6'(s_reg.step[2:0]); // [R01]
                if (s_next.code >= ST_COMP_LAST) begin
                    s_next.code  = ST_COMP_LAST;
                    s_next.phase = TS_TIMEOUT;
                end
            end
            TS_CFG: begin
                // walk width, lane number, completion, idle
                if (s_reg.ctrl[CTRL_ROOT]) begin
                    case (s_reg.step)                            // [R04]
                        4'h0, 4'h1, 4'h2: s_next.code = ST_RP_LW_FIRST + 6'(s_reg.step);
                        4'h3, 4'h4:       s_next.code = ST_RP_WA_FIRST + 6'(s_reg.step - 4'h3);
                        4'h5:             s_next.code = ST_RP_LN_WAIT;
                        4'h6:             s_next.code = ST_RP_LN_ACC;
                        4'h7:             s_next.code = width_code(present);
                        default:          s_next.code = ST_CFG_IDLE;
                    endcase
                end else begin
                    case (s_reg.step)                            // [R02]
                        4'h0, 4'h1, 4'h2, 4'h3: s_next.code = ST_CFG_LW_FIRST + 6'(s_reg.step);
                        4'h4:                   s_next.code = ST_CFG_LN_WAIT;
                        4'h5:                   s_next.code = ST_CFG_LN_ACC;
                        4'h6:                   s_next.code = width_code(present);
                        default:                s_next.code = ST_CFG_IDLE;
                    endcase
                end
                if (s_reg.step == 4'h9) begin
                    s_next.phase = TS_L0;
                    ev[IRQ_LINK_UP] = 1'b1;
                end
            end
            TS_L0: begin
                s_next.code = ST_ACTIVE;                         // [R18]
                s_next.timer = '0;
                s_next.step  = '0;
                if (s_reg.ctrl[CTRL_HOTRST]) s_next.phase = TS_HOTRST;
                else if (s_reg.ctrl[CTRL_DISABLE]) s_next.phase = TS_DIS;
            end
            TS_HOTRST: begin
                s_next.code = ST_HOT_RESET;                      // [R03]
                if (!s_reg.ctrl[CTRL_HOTRST]) begin
                    s_next.phase = TS_DET_QUIET;
                    s_next.step  = '0;
                end
            end
            TS_DIS: begin
                s_next.code = (s_reg.step < 4'h3) ? ST_DIS_FIRST + 6'(s_reg.step)
                                                  : ST_DIS_IDLE; // [R03]
                if (s_reg.step >= 4'h3) s_next.step = 4'h3;
                if (!s_reg.ctrl[CTRL_DISABLE]) begin
                    s_next.phase = TS_DET_QUIET;
                    s_next.step  = '0;
                end
            end
            TS_LOOP: begin
                case (s_reg.step)                                // [R06]
                    4'h0:    s_next.code = s_reg.ctrl[CTRL_ROOT] ? ST_LB_MASTER
                                                                 : ST_LB_ENTRY0;
                    4'h1:    s_next.code = ST_LB_ENTRY1;
                    4'h2:    s_next.code = ST_LB_ACTIVE;
                    4'h3:    s_next.code = ST_LB_EXIT0;
                    default: s_next.code = ST_LB_EXIT1;
                endcase
                if (s_reg.step == 4'h2 && s_reg.ctrl[CTRL_LOOPBACK]) s_next.step = 4'h2;
                if (s_reg.step == 4'h4) begin
                    s_next.phase = TS_DET_QUIET;
                    s_next.step  = '0;
                end
            end
            TS_TIMEOUT: begin
                s_next.code  = ST_TIMEOUT_DET;                   // [R05]
                ev[IRQ_TIMEOUT] = 1'b1;
                s_next.phase = TS_DET_QUIET;
                s_next.step  = '0;
            end
            default: begin
                s_next.phase = TS_DET_QUIET;
            end
        endcase

        // training not finished in time: polling goes to compliance then timeout, detect/config go straight to timeout
        if ((s_reg.phase == TS_POLL || s_reg.phase == TS_CFG || s_reg.phase == TS_DET_ACT)
            && s_reg.timer == 16'(TRAIN_TO)) begin
            s_next.phase = (s_reg.phase == TS_POLL) ? TS_COMP : TS_TIMEOUT;
            s_next.step  = '0;
        end

        ev[IRQ_RX_DONE] = rx_done && !s_reg.rxd_d;               // [R15]
        ev[IRQ_TX_DONE] = tx_done && !s_reg.txd_d;               // [R16]
        for (int i = 0; i < LANES; i++) begin
            if (present[i] && rx_status[3*i+2]) ev[IRQ_RX_ERR] = 1'b1; // [R13]
        end

        // register writes; set wins over clear
        if (wr_en) begin
            case (paddr)
                REG_CTRL:    s_next.ctrl[7:3] = pwdata[7:3];
                REG_IRQ_EN:  s_next.irq_en = pwdata[IRQ_BITS-1:0];
                REG_IRQ_CLR: s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_BITS-1:0];
                default: ;
            endcase
            if (paddr == REG_CTRL && pwdata[CTRL_DET_REQ]) begin
                s_next.phase = TS_DET_QUIET;
                s_next.step  = 4'(STEP_CYCLES);
            end
        end
        s_next.irq_stat = s_next.irq_stat | ev;

        // read data captured in setup phase
        if (rd_en) begin
            case (paddr)
                REG_CTRL:     s_next.rdata = {24'h000000, s_reg.ctrl};
                REG_STATE:    s_next.rdata = {26'h0000000, s_reg.code};  // [R17]
                REG_DETECT:   s_next.rdata = {24'h000000, 8'(present)};
                REG_RXSTAT:   s_next.rdata = {8'h00, 24'(rx_status)};
                REG_IRQ_STAT: s_next.rdata = {26'h0000000, s_reg.irq_stat};
                REG_IRQ_EN:   s_next.rdata = {26'h0000000, s_reg.irq_en};
                default:      s_next.rdata = 32'h00000000;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------
    // outputs
    // ------------------------------
    assign pready               = 1'b1;
    assign pslverr              = psel && penable && !(paddr == REG_CTRL || paddr == REG_STATE
                                  || paddr == REG_DETECT || paddr == REG_RXSTAT
                                  || paddr == REG_IRQ_STAT || paddr == REG_IRQ_EN
                                  || paddr == REG_IRQ_CLR);
    assign prdata               = s_reg.rdata;
    assign training_state_code  = s_reg.code;                    // [R17]
    assign phy_status           = det_phy | {LANES{s_reg.pm_phy}}; // [R09]
    assign rx_channel_reset_req = rx_pulse;                      // [R14]
    assign tx_channel_reset_req = tx_pulse;
    assign rx_reset_done        = rx_done;
    assign tx_reset_done        = tx_done;
    assign irq                  = |(s_reg.irq_stat & s_reg.irq_en);
endmodule

// File: lts_partner.sv
`timescale 1ns/1ps
// far-end lanes: receiver presence and raw receive codes
module lts_partner #(
    parameter int LANES = 4
) (
    input  wire logic             ref_clk,
    input  wire logic [LANES-1:0] mask,
    input  wire logic [2:0]       ev,
    output logic [LANES-1:0]      partner_present,
    output logic [3*LANES-1:0]    rx_event
);
    // present lanes answer detection, every lane sees the same code
    always_ff @(posedge ref_clk) begin
        partner_present <= mask;
        rx_event        <= {LANES{ev}};
    end
endmodule

// File: lts_monitor_sva.sv
`timescale 1ns/1ps
module lts_monitor_sva
    import lts_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic               ref_clk,
    input wire logic               reset,
    input wire logic [5:0]         training_state_code,
    input wire logic [LANES-1:0]   phy_status,
    input wire logic [3*LANES-1:0] rx_status,
    input wire logic               rx_channel_reset_req,
    input wire logic               tx_channel_reset_req,
    input wire logic               rx_reset_done,
    input wire logic               tx_reset_done
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    property p_code; training_state_code inside {[6'h00:6'h16], [6'h21:6'h33]}; endproperty
    a_code: assert property (p_code) else $error("bad code");
    property p_det; $past(training_state_code) == 6'h02 && phy_status[0]
        |-> rx_status[2:0] inside {3'h0, 3'h3}; endproperty
    a_det: assert property (p_det) else $error("bad detect result");
    property p_pulse; phy_status[0] |=> !phy_status[0]; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_rreq; rx_channel_reset_req |=> !rx_channel_reset_req; endproperty
    a_rreq: assert property (p_rreq) else $error("reset req too long");
    property p_rdone; rx_channel_reset_req |=> !rx_reset_done [*8] ##[1:30] rx_reset_done;
    endproperty
    a_rdone: assert property (p_rdone) else $error("rx done wrong");
    property p_tdone; tx_channel_reset_req |=> !tx_reset_done [*8] ##[1:30] tx_reset_done;
    endproperty
    a_tdone: assert property (p_tdone) else $error("tx done wrong");
    property p_tmo; training_state_code == 6'h2D |=> training_state_code inside {6'h2D, 6'h00};
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout exit wrong");
    property p_lbx; training_state_code == 6'h31 |=> training_state_code inside {6'h31, 6'h32};
    endproperty
    a_lbx: assert property (p_lbx) else $error("loop exit wrong");
endmodule
bind lts_monitor lts_monitor_sva #(.LANES(LANES)) u_sva (.*);

// File: link_training_status_monitor_tb_top.sv
`timescale 1ns/1ps
module link_training_status_monitor_tb_top;
    import lts_pkg::*;
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, pm_rate_req, er, irq;
    logic        rx_channel_reset_req, tx_channel_reset_req, rx_reset_done, tx_reset_done;
    logic [11:0] paddr, rx_event, rx_status;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  training_state_code;
    logic [3:0]  partner_present, phy_status, mask;
    logic [2:0]  ev;
    int          err_count, compares;
    lts_monitor #(.LANES(4), .TRAIN_TO(50)) dut (.*);
    lts_partner #(.LANES(4)) u_far (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wcode(input logic [5:0] c);
        for (int n = 0; n < 4000 && training_state_code !== c; n++) @(negedge ref_clk);
        chk(32'(training_state_code), 32'(c));
    endtask
    task automatic t_regs;
        chk(32'(training_state_code), 32'h0);
        apb(1'h0, 12'h100, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask
    task automatic t_train;
        wcode(6'h04);
        wcode(6'h05);
        for (int c = 6'h0B; c < 6'h11; c++) wcode(6'(c));
        wcode(6'h12);
        wcode(6'h16);
        apb(1'h0, REG_DETECT, 32'h0);
        chk(rd, 32'h3);
    endtask
    task automatic t_rx;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            ev <= 3'(i);
            repeat (4) @(negedge ref_clk);
            chk(32'(rx_status), 32'((i == 3) ? 0 : i * 9));
        end
        @(posedge ref_clk);
        {ev, pm_rate_req} <= 4'h1;
        for (int n = 0; n < 8 && phy_status === 4'h0; n++) @(negedge ref_clk);
        chk(32'(phy_status), 32'hF);
        @(posedge ref_clk);
        pm_rate_req <= 1'h0;
    endtask
    task automatic t_chan;
        for (int k = 1; k < 3; k++) begin
            apb(1'h1, REG_CTRL, 32'(1 << k));
            repeat (2) @(negedge ref_clk);
            chk(32'({rx_reset_done, tx_reset_done}), (k == 1) ? 32'h0 : 32'h2);
            for (int n = 0; n < 40 && (k == 1 ? rx_reset_done : tx_reset_done) !== 1'h1; n++)
                @(negedge ref_clk);
            chk(32'({rx_reset_done, tx_reset_done}), (k == 1) ? 32'h2 : 32'h3);
        end
    endtask
    task automatic t_irq;
        chk(32'(irq), 32'h0);
        for (int k = 0; k < 3; k++) begin
            apb(1'h1, (k == 1) ? REG_IRQ_CLR : REG_IRQ_EN, (k == 2) ? 32'h0 : 32'h6);
            repeat (2) @(negedge ref_clk);
            chk(32'(irq), (k == 0) ? 32'h1 : 32'h0);
        end
    endtask
    task automatic t_states;
        apb(1'h1, REG_CTRL, 32'h40);
        wcode(6'h21);
        apb(1'h1, REG_CTRL, 32'h0);
        wcode(6'h16);
        apb(1'h1, REG_CTRL, 32'h20);
        for (int c = 6'h22; c < 6'h26; c++) wcode(6'(c));
        apb(1'h1, REG_CTRL, 32'h11);
        for (int c = 6'h2E; c < 6'h31; c++) wcode(6'(c));
        apb(1'h1, REG_CTRL, 32'h0);
        wcode(6'h31);
        wcode(6'h32);
        apb(1'h1, REG_CTRL, 32'h9);
        for (int c = 6'h26; c < 6'h2D; c++) wcode(6'(c));
        wcode(6'h16);
    endtask
    task automatic close_out;
        if (err_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // clock
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        close_out();
    end
    // main sequence
    initial begin
        {reset, psel, penable, pwrite, pm_rate_req, paddr, pwdata, ev} = {5'h10, 47'h0};
        mask = 4'h3;
        repeat (3) @(posedge ref_clk);
        reset <= 1'h0;
        t_regs();
        t_train();
        t_rx();
        t_chan();
        t_irq();
        t_states();
        close_out();
    end
endmodule
